/* rtl/rmsc_pkg.sv */
/*
  rmsc_pkg: constants, timing counts and state types for the repeater mode
  and sideband control block.
  Assumes a single 50 MHz core clock; times are converted to cycles here.
*/
// Function
// - crossbar orientation taken only at reset; later changes ignored
// - after reset release and ready time, enter default repeater state
// - while chip reset is low, stay powered down
// - in I2C mode first general pin enables UART mode, active low
// - UART mode passes D+ to eD+ and eD- to D-
// - on UART enable rise, after switch time, leave UART mode
// - host or peripheral role from acknowledged eUSB2 configuration
// - UART source select bit moves UART enable to a register bit
// - auto-resume drives resume K and holds remote wake until SOResume
// - resume K starts on USB within hub resume limit
// - L2 interrupt mode disables auto-resume; K driven, eUSB2 held SE0
// - wake after L2 with wake interrupt: interrupt, resume, no eUSB2 wake
// - then wait SOResume without intervening configuration, connect or reset
// - SE0 after L2 with disconnect interrupt: interrupt, hold, await port reset
// - attach detect: debounce attach, then interrupt instead of eUSB2 attach
// - tuning pins start as inputs, sampled in reset, revert on resets
// - tuning pins configurable as output of selected event, open-drain or push-pull
// - input change on tuning pin raises interrupt, edge or level chosen
// - interrupt pin open-drain active low; push-pull polarity selectable
// - interrupt output level, asserted while enabled event pending
// - without I2C host, all three pins are tuning straps only
// - general pins default to UART enable of port 0 and port 1
// - ready no later than ready time after reset release
// - UART to USB mode switch completes within switch time
// - crossbar input latched after reset release and fixed delay
package rmsc_pkg;

  localparam int CLK_MHZ        = 50;
  localparam int READY_TIME_MS  = 3;
  localparam int READY_CYC      = READY_TIME_MS * 1000 * CLK_MHZ;
  localparam int CROSS_DELAY_MS = 1;
  localparam int CROSS_CYC      = CROSS_DELAY_MS * 1000 * CLK_MHZ;
  localparam int MODE_SW_US     = 1;
  localparam int MODE_SW_CYC    = MODE_SW_US * CLK_MHZ;
  localparam int ATTACH_DB_US   = 60;
  localparam int ATTACH_CYC     = ATTACH_DB_US * CLK_MHZ;
  localparam int HUB_RESUME_MS  = 1;
  localparam int UART_START_MS  = 2;
  localparam int NPORT          = 2;
  localparam int MSW_W          = 6;
  localparam int ATT_W          = 12;

  // output event select codes for tuning pins
  localparam logic [1:0] EV_UART  = 2'h0;
  localparam logic [1:0] EV_IRQ   = 2'h1;
  localparam logic [1:0] EV_HOST  = 2'h2;
  localparam logic [1:0] EV_READY = 2'h3;

  // reset values
  localparam logic       CROSS_RST = 1'b0;
  localparam logic [2:0] STRAP_RST = 3'h0;

  typedef enum logic [2:0] {
    PS_RUN,
    PS_L2,
    PS_WAKE_AUTO,
    PS_WAKE_IRQ,
    PS_DISC
  } rmsc_port_e;

endpackage

/* rtl/rmsc_sync.sv */
/*
  rmsc_sync: two flip-flop synchroniser for a bundle of pin levels.
  Assumes each bit is an independent level; no bus coherence is kept.
*/
`timescale 1ns/100ps
module rmsc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] async_lvl,
  output logic      [W-1:0] sync_lvl
);

  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q   <= '0;
      sync_lvl <= '0;
    end else begin
      meta_q   <= async_lvl;
      sync_lvl <= meta_q;
    end
  end

endmodule

/* rtl/rmsc_ctrl.sv */
/*
  rmsc_ctrl: mode and sideband control of a dual repeater: reset sequencing,
  crossbar latch, UART bypass, L2 wake/disconnect/attach interrupts, tuning pins.
  Assumes pins and analog detectors are asynchronous; link events and control
  bits come from logic on core_clk.
*/
`timescale 1ns/100ps
module rmsc_ctrl
  import rmsc_pkg::*;
#(
  parameter int READY_CYCLES = rmsc_pkg::READY_CYC,
  parameter int CROSS_CYCLES = rmsc_pkg::CROSS_CYC
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // chip pins
  input  wire logic       chip_reset_low,
  input  wire logic       cross_pin,
  input  wire logic       i2c_mode,
  input  wire logic       soft_reset,
  // tuning pins
  input  wire logic       tuning_pin_zero_lvl,
  output logic            tuning_pin_zero_drv,
  output logic            tuning_pin_zero_oe,
  input  wire logic       tuning_pin_one_lvl,
  output logic            tuning_pin_one_drv,
  output logic            tuning_pin_one_oe,
  input  wire logic       tuning_irq_pin_lvl,
  output logic            tuning_irq_pin_drv,
  output logic            tuning_irq_pin_oe,
  // pin and interrupt configuration
  input  wire logic [1:0] io_dir_out,
  input  wire logic [1:0] io_push_pull,
  input  wire logic [1:0] io_zero_config,
  input  wire logic [1:0] io_one_config,
  input  wire logic [1:0] io_irq_enable,
  input  wire logic [1:0] io_irq_level,
  input  wire logic [1:0] io_irq_clear,
  input  wire logic       irq_push_pull,
  input  wire logic       irq_active_high,
  // per-port control
  input  wire logic [1:0] uart_source_select,
  input  wire logic [1:0] uart_port_config,
  input  wire logic [1:0] auto_resume_enable,
  input  wire logic [1:0] remote_wake_irq_enable,
  input  wire logic [1:0] disconnect_irq_enable,
  input  wire logic [1:0] attach_detect_irq_enable,
  input  wire logic [1:0] wake_irq_clear,
  input  wire logic [1:0] disc_irq_clear,
  input  wire logic [1:0] attach_irq_clear,
  // eUSB2 link events
  input  wire logic [1:0] cfg_valid,
  input  wire logic [1:0] cfg_host,
  input  wire logic [1:0] cm_l2_rx,
  input  wire logic [1:0] so_resume_rx,
  input  wire logic [1:0] port_reset_rx,
  // USB side detectors and UART data
  input  wire logic [1:0] usb_wake_det,
  input  wire logic [1:0] usb_se0_det,
  input  wire logic [1:0] usb_attach_det,
  input  wire logic [1:0] usb_dp_rx,
  input  wire logic [1:0] eusb_edn_tx,
  // status
  output logic            power_down,
  output logic            ready,
  output logic            cross_sel,
  output logic            cross_valid,
  output logic      [2:0] strap_eq,
  output logic      [1:0] uart_mode,
  output logic      [1:0] role_host,
  output logic      [1:0] wake_sts,
  output logic      [1:0] disc_sts,
  output logic      [1:0] attach_sts,
  output logic      [1:0] io_sts,
  // repeater drive
  output logic      [1:0] eusb_edp_uart,
  output logic      [1:0] usb_dn_uart,
  output logic      [1:0] usb_resume_k,
  output logic      [1:0] eusb_remote_wake,
  output logic      [1:0] eusb_se0_hold,
  output logic      [1:0] eusb_attach_fwd
);

  localparam int CW = $clog2(READY_CYCLES + 1);

  // synchronised pins
  logic [14:0] pin_s;
  logic        crl_s;
  logic        cross_s;
  logic [1:0]  tp_s;
  logic        irqp_s;
  logic [1:0]  wake_s;
  logic [1:0]  se0_s;
  logic [1:0]  att_s;
  logic [1:0]  dp_s;
  logic [1:0]  edn_s;

  rmsc_sync #(.W(15)) u_sync (
    .core_clk  (core_clk),
    .rst       (rst),
    .async_lvl ({chip_reset_low, cross_pin, tuning_pin_one_lvl,
                 tuning_pin_zero_lvl, tuning_irq_pin_lvl, usb_wake_det,
                 usb_se0_det, usb_attach_det, usb_dp_rx, eusb_edn_tx}),
    .sync_lvl  (pin_s)
  );

  assign crl_s   = pin_s[14];
  assign cross_s = pin_s[13];
  assign tp_s    = pin_s[12:11];
  assign irqp_s  = pin_s[10];
  assign wake_s  = pin_s[9:8];
  assign se0_s   = pin_s[7:6];
  assign att_s   = pin_s[5:4];
  assign dp_s    = pin_s[3:2];
  assign edn_s   = pin_s[1:0];

  wire chip_off = ~crl_s;

  // reset sequencing
  logic [CW-1:0] rdy_cnt_q;
  logic          crl_prev_q;
  wire           rdy_hit   = rdy_cnt_q == CW'(READY_CYCLES - 1);
  wire           cross_hit = rdy_cnt_q == CW'(CROSS_CYCLES - 1);
  wire           chip_edge = crl_s ^ crl_prev_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdy_cnt_q   <= '0;
      crl_prev_q  <= 1'b0;
      power_down  <= 1'b1;
      ready       <= 1'b0;
      cross_sel   <= CROSS_RST;
      cross_valid <= 1'b0;
      strap_eq    <= STRAP_RST;
    end else begin
      crl_prev_q <= crl_s;
      power_down <= chip_off;
      if (chip_off) begin
        rdy_cnt_q   <= '0;
        ready       <= 1'b0;
        cross_valid <= 1'b0;
        strap_eq    <= {irqp_s, tp_s};
      end else begin
        if (!ready) begin
          rdy_cnt_q <= rdy_cnt_q + CW'(1);
        end
        if (rdy_hit) begin
          ready <= 1'b1;
        end
        if (cross_hit && !cross_valid) begin
          cross_sel   <= cross_s;
          cross_valid <= 1'b1;
        end
      end
    end
  end

  // tuning pin direction guard
  logic [1:0] out_ok_q;
  wire  [1:0] io_out = io_dir_out & out_ok_q & {2{i2c_mode}};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_ok_q <= 2'h0;
    end else if (chip_off || chip_edge || soft_reset) begin
      out_ok_q <= 2'h0;
    end else begin
      out_ok_q <= out_ok_q | ~io_dir_out;
    end
  end

  // UART bypass request
  // enable source per port
  wire [1:0] uart_req = {2{i2c_mode}}
                      & ((uart_source_select & uart_port_config)
                      | (~uart_source_select & ~tp_s & ~io_out));

  logic [MSW_W-1:0] msw_cnt_q [NPORT];

  // per-port sequencing
  rmsc_port_e st_q [NPORT];
  rmsc_port_e st_d [NPORT];
  logic [ATT_W-1:0] att_cnt_q [NPORT];
  logic [1:0] wake_set;
  logic [1:0] disc_set;
  logic [1:0] att_set;
  logic [1:0] k_d;

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      st_d[p]     = st_q[p];
      wake_set[p] = 1'b0;
      disc_set[p] = 1'b0;
      unique case (st_q[p])
        PS_RUN: begin
          if (role_host[p] && cm_l2_rx[p]) begin
            st_d[p] = PS_L2;
          end
        end
        PS_L2: begin
          if (wake_s[p]) begin
            wake_set[p] = remote_wake_irq_enable[p];
            st_d[p] = remote_wake_irq_enable[p] ? PS_WAKE_IRQ : PS_WAKE_AUTO;
          end else if (se0_s[p] && disconnect_irq_enable[p]) begin
            disc_set[p] = 1'b1;
            st_d[p] = PS_DISC;
          end else if (so_resume_rx[p] || port_reset_rx[p]) begin
            st_d[p] = PS_RUN;
          end
        end
        PS_WAKE_AUTO: begin
          if (so_resume_rx[p]) begin
            st_d[p] = PS_RUN;
          end
        end
        PS_WAKE_IRQ: begin
          if (so_resume_rx[p] || cfg_valid[p] || port_reset_rx[p]) begin
            st_d[p] = PS_RUN;
          end
        end
        PS_DISC: begin
          if (port_reset_rx[p]) begin
            st_d[p] = PS_RUN;
          end
        end
        default: st_d[p] = PS_RUN;
      endcase
      if (uart_mode[p] || !ready) begin
        st_d[p] = PS_RUN;
      end
      k_d[p] = (st_d[p] == PS_WAKE_IRQ)
             || (st_d[p] == PS_WAKE_AUTO && auto_resume_enable[p]);
      att_set[p] = att_cnt_q[p] == ATT_W'(ATTACH_CYC - 1);
    end
  end

  function automatic logic sticky(input logic q, input logic s, input logic c);
    sticky = s | (q & ~c);
  endfunction

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < NPORT; p++) begin
        st_q[p]      <= PS_RUN;
        msw_cnt_q[p] <= '0;
        att_cnt_q[p] <= '0;
      end
      uart_mode        <= 2'h0;
      role_host        <= 2'h0;
      wake_sts         <= 2'h0;
      disc_sts         <= 2'h0;
      attach_sts       <= 2'h0;
      eusb_edp_uart    <= 2'h0;
      usb_dn_uart      <= 2'h0;
      usb_resume_k     <= 2'h0;
      eusb_remote_wake <= 2'h0;
      eusb_se0_hold    <= 2'h0;
      eusb_attach_fwd  <= 2'h0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        st_q[p] <= st_d[p];
        if (ready && uart_req[p] != uart_mode[p]) begin
          msw_cnt_q[p] <= msw_cnt_q[p] + MSW_W'(1);
          if (msw_cnt_q[p] == MSW_W'(MODE_SW_CYC - 1)) begin
            uart_mode[p] <= uart_req[p];
            msw_cnt_q[p] <= '0;
          end
        end else begin
          msw_cnt_q[p] <= '0;
        end
        if (role_host[p] && attach_detect_irq_enable[p] && att_s[p] && !att_set[p]) begin
          att_cnt_q[p] <= att_cnt_q[p] + ATT_W'(1);
        end else if (!att_s[p]) begin
          att_cnt_q[p] <= '0;
        end
        if (cfg_valid[p]) begin
          role_host[p] <= cfg_host[p];
        end
      end
      if (chip_off) begin
        uart_mode <= 2'h0;
        role_host <= 2'h0;
      end
      wake_sts   <= sticky(wake_sts[0], wake_set[0], wake_irq_clear[0])
                  ? {sticky(wake_sts[1], wake_set[1], wake_irq_clear[1]), 1'b1}
                  : {sticky(wake_sts[1], wake_set[1], wake_irq_clear[1]), 1'b0};
      disc_sts   <= disc_set | (disc_sts & ~disc_irq_clear);
      attach_sts <= att_set | (attach_sts & ~attach_irq_clear);
      eusb_edp_uart    <= uart_mode & dp_s;
      usb_dn_uart      <= uart_mode & edn_s;
      usb_resume_k     <= k_d;
      for (int p = 0; p < NPORT; p++) begin
        eusb_remote_wake[p] <= st_d[p] == PS_WAKE_AUTO;
        eusb_se0_hold[p]    <= st_d[p] == PS_WAKE_IRQ || st_d[p] == PS_DISC;
      end
      eusb_attach_fwd  <= att_s & ~uart_mode & ~(role_host & attach_detect_irq_enable);
    end
  end

  // tuning pin input change interrupts
  logic [1:0] tp_prev_q;
  wire  [1:0] io_set = {2{i2c_mode}} & ~io_out
                     & ((io_irq_level & tp_s) | (~io_irq_level & (tp_s ^ tp_prev_q)));

  wire pend = i2c_mode & |((wake_sts & remote_wake_irq_enable)
                         | (disc_sts & disconnect_irq_enable)
                         | (attach_sts & attach_detect_irq_enable)
                         | (io_sts & io_irq_enable));

  function automatic logic ev_pick(input logic [1:0] sel, input logic uart_b, input logic irq_b,
                                   input logic host_b, input logic rdy_b);
    unique case (sel)
      EV_UART:  ev_pick = uart_b;
      EV_IRQ:   ev_pick = irq_b;
      EV_HOST:  ev_pick = host_b;
      EV_READY: ev_pick = rdy_b;
    endcase
  endfunction

  wire [1:0] ev = {ev_pick(io_one_config, uart_mode[1], pend, role_host[1], ready),
                   ev_pick(io_zero_config, uart_mode[0], pend, role_host[0], ready)};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tp_prev_q           <= 2'h0;
      io_sts              <= 2'h0;
      tuning_pin_zero_drv <= 1'b0;
      tuning_pin_zero_oe  <= 1'b0;
      tuning_pin_one_drv  <= 1'b0;
      tuning_pin_one_oe   <= 1'b0;
      tuning_irq_pin_drv  <= 1'b0;
      tuning_irq_pin_oe   <= 1'b0;
    end else begin
      tp_prev_q <= tp_s;
      io_sts    <= io_set | (io_sts & ~io_irq_clear);
      tuning_pin_zero_drv <= io_out[0] & io_push_pull[0] & ev[0];
      tuning_pin_zero_oe  <= io_out[0] & (io_push_pull[0] | ~ev[0]);
      tuning_pin_one_drv  <= io_out[1] & io_push_pull[1] & ev[1];
      tuning_pin_one_oe   <= io_out[1] & (io_push_pull[1] | ~ev[1]);
      tuning_irq_pin_drv  <= i2c_mode & irq_push_pull & (pend ~^ irq_active_high);
      tuning_irq_pin_oe   <= i2c_mode & (irq_push_pull | pend);
    end
  end

  // checks on port 0, disconnect on port 1
  sequence s_l2_wake;
    st_q[0] == PS_L2 && wake_s[0] && !uart_mode[0] && ready;
  endsequence

  property p_pdown;
    @(posedge core_clk) disable iff (rst) chip_off |=> power_down && !ready;
  endproperty
  a_pdown: assert property (p_pdown) else $error("not powered down in reset");

  property p_ready;
    @(posedge core_clk) disable iff (rst) $rose(ready) |-> $past(rdy_cnt_q) == CW'(READY_CYCLES - 1);
  endproperty
  a_ready: assert property (p_ready) else $error("ready at wrong count");

  property p_cross;
    @(posedge core_clk) disable iff (rst) cross_valid && !chip_off |=> $stable(cross_sel);
  endproperty
  a_cross: assert property (p_cross) else $error("crossbar changed after latch");

  property p_msw;
    @(posedge core_clk) disable iff (rst)
      $changed(uart_mode[0]) && !$past(chip_off) |-> $past(msw_cnt_q[0]) == MSW_W'(MODE_SW_CYC - 1);
  endproperty
  a_msw: assert property (p_msw) else $error("mode switch time wrong");

  property p_uart_data;
    @(posedge core_clk) disable iff (rst) uart_mode[0] |=> eusb_edp_uart[0] == $past(dp_s[0]);
  endproperty
  a_uart_data: assert property (p_uart_data) else $error("uart receive path wrong");

  property p_wake_irq;
    @(posedge core_clk) disable iff (rst)
      s_l2_wake and remote_wake_irq_enable[0]
      |=> wake_sts[0] && usb_resume_k[0] && eusb_se0_hold[0] && !eusb_remote_wake[0];
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake interrupt sequence wrong");

  property p_auto;
    @(posedge core_clk) disable iff (rst)
      s_l2_wake and !remote_wake_irq_enable[0] and auto_resume_enable[0]
      |=> usb_resume_k[0] && eusb_remote_wake[0];
  endproperty
  a_auto: assert property (p_auto) else $error("auto-resume not driven");

  property p_disc;
    @(posedge core_clk) disable iff (rst)
      st_q[1] == PS_L2 && !wake_s[1] && se0_s[1] && disconnect_irq_enable[1] && ready && !uart_mode[1]
      |=> disc_sts[1] && eusb_se0_hold[1];
  endproperty
  a_disc: assert property (p_disc) else $error("disconnect interrupt missing");

  property p_attach;
    @(posedge core_clk) disable iff (rst) $rose(attach_sts[0]) |-> $past(att_cnt_q[0]) == ATT_W'(ATTACH_CYC - 1);
  endproperty
  a_attach: assert property (p_attach) else $error("attach debounce wrong");

  property p_sticky;
    @(posedge core_clk) disable iff (rst) wake_sts[0] && !wake_irq_clear[0] |=> wake_sts[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost without clear");

  property p_irq_od;
    @(posedge core_clk) disable iff (rst) i2c_mode && !irq_push_pull |=> tuning_irq_pin_oe == $past(pend) && !tuning_irq_pin_drv;
  endproperty
  a_irq_od: assert property (p_irq_od) else $error("interrupt pin drive wrong");

  property p_strap;
    @(posedge core_clk) disable iff (rst) !i2c_mode |=> !tuning_irq_pin_oe ##0 !tuning_pin_zero_oe;
  endproperty
  a_strap: assert property (p_strap) else $error("strap pin driven");

endmodule

/* test/rmsc_soc_model.sv */
/*
  rmsc_soc_model: link-side port controller issuing one-cycle link events.
  Assumes the caller runs 2 ns after a rising edge of core_clk.
*/
`timescale 1ns/100ps
module rmsc_soc_model (
  // clock
  input  wire logic       core_clk,
  // link events toward the repeater
  output logic      [1:0] cfg_valid,
  output logic      [1:0] cfg_host,
  output logic      [1:0] cm_l2_rx,
  output logic      [1:0] so_resume_rx,
  output logic      [1:0] port_reset_rx
);
  initial begin
    {cfg_valid, cfg_host, cm_l2_rx, so_resume_rx, port_reset_rx} = 10'h0;
  end

  // one event after lag + 1 cycles; kind 0 cfg, 1 l2, 2 resume, 3 port reset
  task automatic pulse(input int kind, input int port, input logic host, input int lag);
    repeat (lag) @(posedge core_clk);
    @(posedge core_clk);
    #2;
    case (kind)
      0: begin
        cfg_valid[port] = 1'b1;
        cfg_host[port]  = host;
      end
      1: cm_l2_rx[port] = 1'b1;
      2: so_resume_rx[port] = 1'b1;
      default: port_reset_rx[port] = 1'b1;
    endcase
    @(posedge core_clk);
    #2;
    {cfg_valid, cm_l2_rx, so_resume_rx, port_reset_rx} = 8'h0;
  endtask
endmodule

/* test/testbench.sv */
/*
  testbench: scenario tasks for rmsc_ctrl with a link-side model.
  Assumes inputs change 2 ns after the edge; a released interrupt pin is pulled up, released tuning pins follow tp0 and tp1.
*/
`timescale 1ns/100ps
module testbench;
  import rmsc_pkg::*;
  localparam int RDY = 40;
  localparam int CRS = 20;
  logic       core_clk, rst, chip_reset_low, cross_pin, i2c_mode, soft_reset;
  logic       irq_push_pull, irq_active_high, tp0, tp1, z_drv, z_oe, o_drv, o_oe, q_drv, q_oe;
  logic       power_down, ready, cross_sel, cross_valid;
  logic [2:0] strap_eq;
  logic [1:0] io_dir_out, io_push_pull, io_zero_config, io_one_config, io_irq_enable, io_irq_level, io_irq_clear;
  logic [1:0] uart_source_select, uart_port_config, auto_resume_enable, remote_wake_irq_enable;
  logic [1:0] disconnect_irq_enable, attach_detect_irq_enable, wake_irq_clear, disc_irq_clear, attach_irq_clear;
  logic [1:0] cfg_valid, cfg_host, cm_l2_rx, so_resume_rx, port_reset_rx;
  logic [1:0] usb_wake_det, usb_se0_det, usb_attach_det, usb_dp_rx, eusb_edn_tx;
  logic [1:0] uart_mode, role_host, wake_sts, disc_sts, attach_sts, io_sts;
  logic [1:0] eusb_edp_uart, usb_dn_uart, usb_resume_k, eusb_remote_wake, eusb_se0_hold, eusb_attach_fwd;
  int         err_total, tests_run;
  wire logic  z_lvl = z_oe ? z_drv : tp0;
  wire logic  o_lvl = o_oe ? o_drv : tp1;
  wire logic  q_lvl = q_oe ? q_drv : 1'b1;

  rmsc_ctrl #(.READY_CYCLES(RDY), .CROSS_CYCLES(CRS)) rmsc_ctrl_i (
    .core_clk, .rst, .chip_reset_low, .cross_pin, .i2c_mode, .soft_reset,
    .tuning_pin_zero_lvl(z_lvl), .tuning_pin_zero_drv(z_drv), .tuning_pin_zero_oe(z_oe),
    .tuning_pin_one_lvl(o_lvl), .tuning_pin_one_drv(o_drv), .tuning_pin_one_oe(o_oe),
    .tuning_irq_pin_lvl(q_lvl), .tuning_irq_pin_drv(q_drv), .tuning_irq_pin_oe(q_oe),
    .io_dir_out, .io_push_pull, .io_zero_config, .io_one_config, .io_irq_enable, .io_irq_level,
    .io_irq_clear, .irq_push_pull, .irq_active_high, .uart_source_select, .uart_port_config,
    .auto_resume_enable, .remote_wake_irq_enable, .disconnect_irq_enable, .attach_detect_irq_enable,
    .wake_irq_clear, .disc_irq_clear, .attach_irq_clear, .cfg_valid, .cfg_host, .cm_l2_rx,
    .so_resume_rx, .port_reset_rx, .usb_wake_det, .usb_se0_det, .usb_attach_det, .usb_dp_rx,
    .eusb_edn_tx, .power_down, .ready, .cross_sel, .cross_valid, .strap_eq, .uart_mode, .role_host,
    .wake_sts, .disc_sts, .attach_sts, .io_sts, .eusb_edp_uart, .usb_dn_uart, .usb_resume_k,
    .eusb_remote_wake, .eusb_se0_hold, .eusb_attach_fwd
  );

  rmsc_soc_model soc_i (
    .core_clk, .cfg_valid, .cfg_host, .cm_l2_rx, .so_resume_rx, .port_reset_rx
  );

  always #10 core_clk = ~core_clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out;
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic t_reset;
    cross_pin = 1'b1;
    cyc(4);
    chk("power_down", 4'h1, power_down);
    chk("ready", 4'h0, ready);
    chk("strap_eq", 4'h7, strap_eq);
    chip_reset_low = 1'b1;
    for (int i = 0; i < RDY + 8 && ready !== 1'b1; i++) cyc(1);
    chk("ready", 4'h1, ready);
    chk("power_down", 4'h0, power_down);
    chk("cross", 4'h3, {cross_valid, cross_sel});
    cross_pin = 1'b0;
    cyc(6);
    chk("cross_sel", 4'h1, cross_sel);
  endtask

  task automatic t_uart;
    i2c_mode = 1'b1;
    tp0 = 1'b0;
    cyc(58);
    chk("uart_mode", 4'h1, uart_mode);
    usb_dp_rx = 2'h1;
    eusb_edn_tx = 2'h1;
    cyc(5);
    chk("uart path", 4'h5, {eusb_edp_uart, usb_dn_uart});
    usb_dp_rx = 2'h0;
    eusb_edn_tx = 2'h0;
    cyc(5);
    chk("uart path", 4'h0, {eusb_edp_uart, usb_dn_uart});
    tp0 = 1'b1;
    cyc(58);
    chk("uart_mode", 4'h0, uart_mode);
    uart_source_select = 2'h2;
    uart_port_config = 2'h2;
    cyc(58);
    chk("uart_mode", 4'h2, uart_mode);
    uart_port_config = 2'h0;
    cyc(58);
    chk("uart_mode", 4'h0, uart_mode);
    uart_source_select = 2'h0;
  endtask

  task automatic t_wake;
    soc_i.pulse(0, 0, 1'b1, 0);
    cyc(3);
    chk("role_host", 4'h1, role_host);
    auto_resume_enable = 2'h1;
    soc_i.pulse(1, 0, 1'b0, 3);
    usb_wake_det = 2'h1;
    cyc(5);
    chk("resume", 4'h5, {usb_resume_k, eusb_remote_wake});
    soc_i.pulse(2, 0, 1'b0, 20);
    cyc(2);
    chk("remote_wake", 4'h0, eusb_remote_wake);
    usb_wake_det = 2'h0;
    remote_wake_irq_enable = 2'h1;
    soc_i.pulse(1, 0, 1'b0, 2);
    usb_wake_det = 2'h1;
    cyc(5);
    chk("wake irq", 4'h5, {wake_sts, usb_resume_k});
    chk("eusb side", 4'h1, {eusb_remote_wake, eusb_se0_hold});
    chk("irq pin", 4'h2, {q_oe, q_lvl});
    irq_push_pull = 1'b1;
    irq_active_high = 1'b1;
    cyc(2);
    chk("irq pp high", 4'h3, {q_oe, q_drv});
    irq_active_high = 1'b0;
    cyc(2);
    chk("irq pp low", 4'h2, {q_oe, q_drv});
    irq_push_pull = 1'b0;
    soc_i.pulse(2, 0, 1'b0, 4);
    cyc(2);
    chk("se0 hold", 4'h0, eusb_se0_hold);
    chk("wake_sts", 4'h1, wake_sts);
    usb_wake_det = 2'h0;
    cyc(3);
    wake_irq_clear = 2'h1;
    cyc(1);
    wake_irq_clear = 2'h0;
    cyc(2);
    chk("wake clear", 4'h0, {wake_sts, q_oe});
  endtask

  task automatic t_disc;
    disconnect_irq_enable = 2'h2;
    soc_i.pulse(0, 1, 1'b1, 0);
    soc_i.pulse(1, 1, 1'b0, 0);
    usb_se0_det = 2'h2;
    cyc(5);
    chk("disc", 4'ha, {disc_sts, eusb_se0_hold});
    chk("wake_sts", 4'h0, wake_sts);
    usb_se0_det = 2'h0;
    cyc(3);
    disc_irq_clear = 2'h2;
    cyc(1);
    disc_irq_clear = 2'h0;
    cyc(2);
    chk("disc_sts", 4'h0, disc_sts);
    soc_i.pulse(3, 1, 1'b0, 2);
    cyc(2);
    chk("se0 hold", 4'h0, eusb_se0_hold);
  endtask

  task automatic t_attach;
    attach_detect_irq_enable = 2'h1;
    usb_attach_det = 2'h1;
    cyc(ATTACH_CYC - 20);
    chk("attach early", 4'h0, {attach_sts, eusb_attach_fwd});
    cyc(40);
    chk("attach", 4'h4, {attach_sts, eusb_attach_fwd});
    usb_attach_det = 2'h0;
    cyc(3);
    attach_irq_clear = 2'h1;
    cyc(1);
    attach_irq_clear = 2'h0;
    attach_detect_irq_enable = 2'h0;
    usb_attach_det = 2'h1;
    cyc(5);
    chk("attach fwd", 4'h1, {attach_sts, eusb_attach_fwd});
    usb_attach_det = 2'h0;
  endtask

  task automatic t_io;
    io_irq_enable = 2'h2;
    tp1 = 1'b0;
    cyc(5);
    chk("io edge", 4'h1, io_sts[1]);
    tp1 = 1'b1;
    io_irq_level = 2'h2;
    cyc(3);
    io_irq_clear = 2'h2;
    cyc(1);
    io_irq_clear = 2'h0;
    cyc(3);
    chk("io level", 4'h1, io_sts[1]);
    io_dir_out = 2'h3;
    io_zero_config = EV_READY;
    io_one_config = EV_IRQ;
    io_push_pull = 2'h3;
    cyc(3);
    chk("pp out", 4'hf, {o_oe, o_drv, z_oe, z_drv});
    io_push_pull = 2'h0;
    cyc(3);
    chk("od out", 4'h0, {o_oe, z_oe});
    io_zero_config = EV_UART;
    io_one_config = EV_HOST;
    cyc(3);
    chk("od low", 4'h2, {o_oe, z_oe, z_drv});
    soft_reset = 1'b1;
    cyc(1);
    soft_reset = 1'b0;
    cyc(3);
    chk("soft reset", 4'h0, z_oe);
    i2c_mode = 1'b0;
    cyc(3);
    chk("straps", 4'h0, {q_oe, o_oe, z_oe});
    chip_reset_low = 1'b0;
    cyc(4);
    chk("power down", 4'h2, {power_down, ready});
  endtask

  initial begin
    core_clk = 1'b0;
    {rst, chip_reset_low, cross_pin, i2c_mode, soft_reset, irq_push_pull, irq_active_high} = 7'h40;
    {tp0, tp1} = 2'h3;
    {io_dir_out, io_push_pull, io_zero_config, io_one_config, io_irq_enable, io_irq_level, io_irq_clear} = 14'h0;
    {uart_source_select, uart_port_config, auto_resume_enable, remote_wake_irq_enable} = 8'h0;
    {disconnect_irq_enable, attach_detect_irq_enable, wake_irq_clear, disc_irq_clear, attach_irq_clear} = 10'h0;
    {usb_wake_det, usb_se0_det, usb_attach_det, usb_dp_rx, eusb_edn_tx} = 10'h0;
    err_total = 0;
    tests_run = 0;
    cyc(2);
    rst = 1'b0;
    t_reset();
    t_uart();
    t_wake();
    t_disc();
    t_attach();
    t_io();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    close_out();
  end
endmodule
